// ===== sim/tef_core_model.sv
// Traced core model: single comparator hits and range presence
`timescale 1ns/1ps
`default_nettype none
module tef_core_model (
	input wire logic i_clk, // Clock
	input wire logic [4:0] i_hit, // Comparator to hit, 0 none
	input wire logic i_in_range, // Core inside range 1
	output logic [15:0] o_single_match, // Single hits
	output logic [7:0] o_range_match // Range hits
);
	always_ff @(posedge i_clk) begin
		o_single_match <= (i_hit != 5'h0) ? (16'h1 << (i_hit - 5'h1)) : 16'h0;
		o_range_match <= {7'h0, i_in_range};
	end
endmodule : tef_core_model
`default_nettype wire

// ===== sim/tef_regs_test.sv
// Register and trace gate tests for the trace gate register bank
`timescale 1ns/1ps
`default_nettype none
module tef_regs_test;
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, in_rng = 1'b0;
	logic [7:0] addr = 8'h0, free = 8'hff;
	logic [31:0] wdata = 32'h0, rdata;
	logic [4:0] hit = 5'h0;
	logic [15:0] smatch;
	logic [7:0] rmatch;
	logic [127:0] res = 128'h2;
	logic gate_o, stall_o;
	int fails = 0, total_checks = 0;
	initial begin
		forever #2 clk = ~clk;
	end
	tef_core_model i_tef_core_model (.i_clk(clk), .i_hit(hit), .i_in_range(in_rng),
		.o_single_match(smatch), .o_range_match(rmatch));
	tef_regs i_tef_regs (.i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr_s), .i_rd(rd_s), .o_rdata(rdata), .i_num_proc_m1(3'h5),
		.i_sys_stall_ok(1'b1), .i_single_match(smatch), .i_range_match(rmatch),
		.i_resources(res), .i_free_bytes(free), .o_trace_gate(gate_o),
		.o_buffer_near_full_stall(stall_o));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr <= a;
		wdata <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		@(posedge clk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 chk(n, e, rdata);
		@(posedge clk);
	endtask : rd
	task automatic gate(input logic e, input string n);
		repeat (4) @(posedge clk);
		#1 chk(n, {31'h0, e}, {31'h0, gate_o});
		@(posedge clk);
	endtask : gate
	task automatic finish_test;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	initial begin
		#20000 fails++;
		finish_test;
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(8'h00, 32'h0000_5100, "feature");
		wr(8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h0000_5100, "feature_ro");
		rd(8'h0c, 32'h0, "control_rst");
		rd(8'h10, 32'h80, "level_rst");
		wr(8'h04, 32'hffff_ffff);
		rd(8'h04, 32'hffff_ffff, "select");
		wr(8'h08, 32'hffff_ffff);
		rd(8'h08, 32'h0001_ffff, "event");
		wr(8'h0c, 32'hffff_ffff);
		rd(8'h0c, 32'h0300_00ff, "control");
		rd(8'h20, 32'h0, "unmapped");
		wr(8'h04, 32'h0);
		wr(8'h08, 32'h1);
		wr(8'h0c, 32'h0100_0000); // Exclude nothing
		gate(1'b1, "trace_all");
		res <= 128'h0;
		gate(1'b0, "event_off");
		res <= 128'h2;
		wr(8'h0c, 32'h0000_0001);
		gate(1'b0, "incl_out");
		in_rng <= 1'b1;
		gate(1'b1, "incl_in");
		wr(8'h0c, 32'h0100_0001);
		gate(1'b0, "excl_in");
		wr(8'h0c, 32'h0300_0000);
		wr(8'h04, 32'h0002_0001);
		gate(1'b0, "ss_idle");
		hit <= 5'h1;
		@(posedge clk);
		hit <= 5'h0;
		gate(1'b1, "ss_on");
		rd(8'h14, 32'h4, "status_on");
		hit <= 5'h2;
		@(posedge clk);
		hit <= 5'h0;
		gate(1'b0, "ss_off");
		rd(8'h14, 32'h0, "status_off");
		wr(8'h08, 32'h5f);
		wr(8'h0c, 32'h0100_0000);
		gate(1'b0, "res5f_idle");
		hit <= 5'h1;
		@(posedge clk);
		hit <= 5'h0;
		gate(1'b1, "res5f_on");
		wr(8'h08, 32'h0000_80df);
		gate(1'b1, "fn_a_and_b");
		wr(8'h08, 32'h0000_405f);
		gate(1'b0, "fn_not_a");
		wr(8'h08, 32'h0001_4080);
		gate(1'b1, "fn_a_or_b");
		wr(8'h08, 32'h0001_805f);
		gate(1'b0, "fn_not_a_or_b");
		wr(8'h10, 32'hff);
		rd(8'h10, 32'h80, "level_clamp");
		wr(8'h10, 32'h10);
		free <= 8'h0f;
		repeat (4) @(posedge clk);
		#1 chk("stall_on", 32'h1, {31'h0, stall_o});
		@(posedge clk);
		free <= 8'h10;
		repeat (4) @(posedge clk);
		#1 chk("stall_off", 32'h0, {31'h0, stall_o});
		finish_test;
	end
endmodule : tef_regs_test
`default_nettype wire

// ===== src/tef_map.svh
// Register offsets, field positions and reset values of the trace gate register bank
`ifndef TEF_MAP_SVH
`define TEF_MAP_SVH
`define TEF_ADDR_W 8
`define TEF_OFF_SYS_FEATURE 8'h00
`define TEF_OFF_SS_SELECT 8'h04
`define TEF_OFF_GATE_EVENT 8'h08
`define TEF_OFF_GATE_CONTROL 8'h0c
`define TEF_OFF_FULL_LEVEL 8'h10
`define TEF_OFF_STATUS 8'h14
`define TEF_SF_NPROC_LSB 12
`define TEF_SF_NPROC_MSB 14
`define TEF_SF_STALL_BIT 8
`define TEF_SS_STOP_LSB 16
`define TEF_EV_W 17
`define TEF_EV_FUNC_LSB 14
`define TEF_EV_RES_B_LSB 7
`define TEF_RES_W 7
`define TEF_RES_START_STOP 7'h5f
`define TEF_CT_SS_EN_BIT 25
`define TEF_CT_EXCL_BIT 24
`define TEF_CT_RANGE_W 8
`define TEF_FL_W 8
`define TEF_ST_SS_BIT 2
`define TEF_RST_SS_SELECT 32'h0000_0000
`define TEF_RST_GATE_EVENT 17'h0_0000
`define TEF_RST_GATE_CONTROL 32'h0000_0000
`endif

// ===== src/tef_pkg.sv
// Types shared by the trace gate register bank
package tef_pkg;
	typedef enum logic [2:0] {
		TEF_FN_A, TEF_FN_NOT_A, TEF_FN_A_AND_B, TEF_FN_NOT_A_AND_B,
		TEF_FN_NOT_A_AND_NOT_B, TEF_FN_A_OR_B, TEF_FN_NOT_A_OR_B, TEF_FN_NOT_A_OR_NOT_B
	} tef_func_t;
endpackage : tef_pkg

// ===== src/tef_regs.sv
// Trace gate configuration registers, start/stop state and trace gating logic
// Operation
// R1: Feature register reports processor count minus one
// R2: Feature stall bit reflects system stall support
// R3: Software uses stall only when both bits set
// R4: Feature register driven by tie-off inputs
// R5: Upper select half picks trace-off comparators
// R6: Lower select half picks trace-on comparators
// R7: Event register holds function plus two resources
// R8: Start/stop gating bit enables start/stop control
// R9: Start/stop resource tracks regardless of gating
// R10: Include mode traces only inside ranges
// R11: Exclude mode suppresses trace inside ranges
// R12: Control low byte selects range comparators
// R13: Trace all: exclude nothing, event always true
// R14: Buffer full level sets near-full threshold
// R15: Gate event enables trace generation
// R16: Status shows start seen without stop
// R17: Reserved fields read zero, ignore writes
// R18: Trace gate ANDs event, region and start/stop
`timescale 1ns/1ps
`default_nettype none
`include "tef_map.svh"
module tef_regs
	import tef_pkg::*;
#(
	parameter int N_SINGLE = 16,
	parameter int N_RANGE = 8,
	parameter int N_RES = 128,
	parameter logic [7:0] FIFO_SIZE = 8'h80
) (
	input wire logic i_clk, // 250 MHz clock
	input wire logic i_sys_rst, // Synchronous reset, active high
	input wire logic [`TEF_ADDR_W-1:0] i_addr, // Register byte address
	input wire logic [31:0] i_wdata, // Write data
	input wire logic i_wr, // Write strobe
	input wire logic i_rd, // Read strobe
	output logic [31:0] o_rdata, // Read data, cycle after strobe
	input wire logic [2:0] i_num_proc_m1, // Tie-off: processors minus one
	input wire logic i_sys_stall_ok, // Tie-off: system stall support
	input wire logic [N_SINGLE-1:0] i_single_match, // Single comparator hits
	input wire logic [N_RANGE-1:0] i_range_match, // Range comparator hits
	input wire logic [N_RES-1:0] i_resources, // Event resources except 0x5f
	input wire logic [7:0] i_free_bytes, // Free bytes in trace buffer
	output logic o_trace_gate, // Trace generation enabled
	output logic o_buffer_near_full_stall // Free space below level
);
	////////////////////////////////////////////////////////////////
	logic [N_SINGLE-1:0] ss_start;
	logic [N_SINGLE-1:0] ss_stop;
	logic [`TEF_EV_W-1:0] gate_event;
	logic ss_en;
	logic excl;
	logic [N_RANGE-1:0] range_sel;
	logic [`TEF_FL_W-1:0] full_level;
	logic ss_state;
	logic [31:0] sys_feature;
	logic [N_RES-1:0] res_all;
	logic res_a, res_b, event_ok, in_region, region_ok, next_gate;

	// Tie-off driven, no storage
	always_comb begin
		sys_feature = 32'h0;
		sys_feature[`TEF_SF_NPROC_MSB:`TEF_SF_NPROC_LSB] = i_num_proc_m1; // [R1] [R4]
		sys_feature[`TEF_SF_STALL_BIT] = i_sys_stall_ok; // [R2] [R4]
	end

	////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ss_start <= N_SINGLE'(`TEF_RST_SS_SELECT);
			ss_stop <= N_SINGLE'(`TEF_RST_SS_SELECT);
		end else if (i_wr && i_addr == `TEF_OFF_SS_SELECT) begin
			ss_start <= i_wdata[N_SINGLE-1:0]; // [R6]
			ss_stop <= i_wdata[`TEF_SS_STOP_LSB +: N_SINGLE]; // [R5]
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			gate_event <= `TEF_RST_GATE_EVENT;
		else if (i_wr && i_addr == `TEF_OFF_GATE_EVENT)
			gate_event <= i_wdata[`TEF_EV_W-1:0]; // [R7] [R17]
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			ss_en <= 1'b0;
			excl <= 1'b0;
			range_sel <= N_RANGE'(`TEF_RST_GATE_CONTROL);
		end else if (i_wr && i_addr == `TEF_OFF_GATE_CONTROL) begin
			ss_en <= i_wdata[`TEF_CT_SS_EN_BIT];
			excl <= i_wdata[`TEF_CT_EXCL_BIT];
			range_sel <= i_wdata[N_RANGE-1:0]; // [R12] [R17]
		end
	end

	// Oversize levels clamp to the buffer size
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			full_level <= FIFO_SIZE;
		else if (i_wr && i_addr == `TEF_OFF_FULL_LEVEL)
			full_level <= (i_wdata[7:0] > FIFO_SIZE) ? FIFO_SIZE : i_wdata[7:0]; // [R14]
	end

	////////////////////////////////////////////////////////////////
	// Start/stop latch runs whatever the gating bit; stop wins on a tie
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			ss_state <= 1'b0;
		else if (|(i_single_match & ss_stop))
			ss_state <= 1'b0; // [R5] [R9]
		else if (|(i_single_match & ss_start))
			ss_state <= 1'b1; // [R6] [R9] [R16]
	end

	always_comb begin
		res_all = i_resources;
		res_all[`TEF_RES_START_STOP] = ss_state; // [R9]
		res_a = res_all[gate_event[`TEF_RES_W-1:0]];
		res_b = res_all[gate_event[`TEF_EV_RES_B_LSB +: `TEF_RES_W]];
		unique case (tef_func_t'(gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB])) // [R7]
			TEF_FN_A: event_ok = res_a;
			TEF_FN_NOT_A: event_ok = !res_a;
			TEF_FN_A_AND_B: event_ok = res_a && res_b;
			TEF_FN_NOT_A_AND_B: event_ok = !res_a && res_b;
			TEF_FN_NOT_A_AND_NOT_B: event_ok = !res_a && !res_b;
			TEF_FN_A_OR_B: event_ok = res_a || res_b;
			TEF_FN_NOT_A_OR_B: event_ok = !res_a || res_b;
			TEF_FN_NOT_A_OR_NOT_B: event_ok = !res_a || !res_b;
		endcase
		in_region = |(i_range_match & range_sel); // [R12]
		region_ok = excl ? !in_region : in_region; // [R10] [R11]
		next_gate = event_ok && region_ok && (!ss_en || ss_state); // [R8] [R15] [R18]
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_trace_gate <= 1'b0;
		else
			o_trace_gate <= next_gate; // [R18]
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_buffer_near_full_stall <= 1'b0;
		else
			o_buffer_near_full_stall <= (i_free_bytes < full_level); // [R14]
	end

	////////////////////////////////////////////////////////////////
	// Unmapped addresses read zero
	always_ff @(posedge i_clk) begin
		if (i_sys_rst)
			o_rdata <= 32'h0;
		else if (!i_rd)
			o_rdata <= 32'h0;
		else begin
			o_rdata <= 32'h0; // [R17]
			unique case (i_addr)
				`TEF_OFF_SYS_FEATURE: o_rdata <= sys_feature; // [R1] [R2]
				`TEF_OFF_SS_SELECT: o_rdata <= {ss_stop, ss_start};
				`TEF_OFF_GATE_EVENT: o_rdata <= {15'h0, gate_event};
				`TEF_OFF_GATE_CONTROL:
					o_rdata <= {6'h0, ss_en, excl, 16'h0, range_sel};
				`TEF_OFF_FULL_LEVEL: o_rdata <= {24'h0, full_level};
				`TEF_OFF_STATUS: o_rdata <= {29'h0, ss_state, 2'h0}; // [R16]
				default: o_rdata <= 32'h0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	stop_wins_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R5]
		|(i_single_match & ss_stop) |=> !ss_state)
		else $error("stop match did not clear start/stop state");
	start_sets_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R6]
		(|(i_single_match & ss_start) && !(|(i_single_match & ss_stop))) |=> ss_state)
		else $error("start match did not set start/stop state");
	ss_hold_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R9]
		!(|(i_single_match & (ss_start | ss_stop))) |=> $stable(ss_state))
		else $error("start/stop state moved with no match");
	ss_gating_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R8]
		(ss_en && !ss_state) |=> !o_trace_gate)
		else $error("trace on while start/stop off");
	include_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R10]
		(!excl && !(|(i_range_match & range_sel))) |=> !o_trace_gate)
		else $error("trace outside include region");
	exclude_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R11]
		(excl && |(i_range_match & range_sel)) |=> !o_trace_gate)
		else $error("trace inside exclude region");
	event_gate_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R15]
		!event_ok |=> !o_trace_gate)
		else $error("trace on without enabling event");
	feature_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R1]
		(i_rd && i_addr == `TEF_OFF_SYS_FEATURE) |=>
		o_rdata == {17'h0, $past(i_num_proc_m1), 3'h0, $past(i_sys_stall_ok), 8'h0})
		else $error("feature register read mismatch");
	status_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R16]
		(i_rd && i_addr == `TEF_OFF_STATUS) |=> o_rdata[`TEF_ST_SS_BIT] == $past(ss_state))
		else $error("status start/stop flag mismatch");
	full_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
		(i_free_bytes < full_level) |=> o_buffer_near_full_stall)
		else $error("near-full not raised below level");
	stall_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
		!(i_free_bytes < full_level) |=> !o_buffer_near_full_stall)
		else $error("near-full raised at or above level");
	// Gate opens when every condition holds
	range_pick_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
		(!excl && |(i_range_match & range_sel) && event_ok && !ss_en)
		|=> o_trace_gate)
		else $error("trace blocked inside include region");
	excl_out_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R11]
		(excl && !(|(i_range_match & range_sel)) && event_ok && !ss_en)
		|=> o_trace_gate)
		else $error("trace blocked outside exclude region");
	gate_on_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R18]
		(event_ok && region_ok && ss_state) |=> o_trace_gate)
		else $error("trace gate low with all conditions met");

	////////////////////////////////////////////////////////////////
	// Event function decode
	func_a_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h0
		|-> event_ok == res_a)
		else $error("function A decode mismatch");
	func_not_a_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h1
		|-> event_ok == !res_a)
		else $error("function not A decode mismatch");
	func_and_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h2
		|-> event_ok == (res_a && res_b))
		else $error("function A and B decode mismatch");
	func_nab_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h3
		|-> event_ok == (!res_a && res_b))
		else $error("function not A and B decode mismatch");
	func_nor_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h4
		|-> event_ok == (!res_a && !res_b))
		else $error("function not A and not B decode mismatch");
	func_or_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h5
		|-> event_ok == (res_a || res_b))
		else $error("function A or B decode mismatch");
	func_naob_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h6
		|-> event_ok == (!res_a || res_b))
		else $error("function not A or B decode mismatch");
	func_nand_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h7
		|-> event_ok == (!res_a || !res_b))
		else $error("function not A or not B decode mismatch");

	////////////////////////////////////////////////////////////////
	// Register read data
	select_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R5] [R6]
		(i_rd && i_addr == `TEF_OFF_SS_SELECT)
		|=> o_rdata == {$past(ss_stop), $past(ss_start)})
		else $error("select register read mismatch");
	event_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		(i_rd && i_addr == `TEF_OFF_GATE_EVENT)
		|=> o_rdata == {15'h0, $past(gate_event)})
		else $error("event register read mismatch");
	control_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R12]
		(i_rd && i_addr == `TEF_OFF_GATE_CONTROL)
		|=> o_rdata == {6'h0, $past(ss_en), $past(excl), 16'h0, $past(range_sel)})
		else $error("control register read mismatch");
	level_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
		(i_rd && i_addr == `TEF_OFF_FULL_LEVEL)
		|=> o_rdata == {24'h0, $past(full_level)})
		else $error("level register read mismatch");
	idle_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R17]
		!i_rd |=> o_rdata == 32'h0)
		else $error("read data not zero without read");
	unmapped_read_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R17]
		(i_rd && i_addr > `TEF_OFF_STATUS) |=> o_rdata == 32'h0)
		else $error("unmapped address read not zero");
	status_rsv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R17]
		(i_rd && i_addr == `TEF_OFF_STATUS)
		|=> (o_rdata[31:3] == 29'h0 && o_rdata[1:0] == 2'h0))
		else $error("status reserved bits not zero");

	////////////////////////////////////////////////////////////////
	// Register writes
	start_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R6]
		(i_wr && i_addr == `TEF_OFF_SS_SELECT)
		|=> ss_start == $past(i_wdata[N_SINGLE-1:0]))
		else $error("start select write mismatch");
	stop_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R5]
		(i_wr && i_addr == `TEF_OFF_SS_SELECT)
		|=> ss_stop == $past(i_wdata[`TEF_SS_STOP_LSB +: N_SINGLE]))
		else $error("stop select write mismatch");
	event_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R7]
		(i_wr && i_addr == `TEF_OFF_GATE_EVENT)
		|=> gate_event == $past(i_wdata[`TEF_EV_W-1:0]))
		else $error("event write mismatch");
	control_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R8]
		(i_wr && i_addr == `TEF_OFF_GATE_CONTROL)
		|=> (ss_en == $past(i_wdata[`TEF_CT_SS_EN_BIT]) && excl == $past(i_wdata[`TEF_CT_EXCL_BIT])
		&& range_sel == $past(i_wdata[N_RANGE-1:0])))
		else $error("control write mismatch");
	level_clamp_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
		(i_wr && i_addr == `TEF_OFF_FULL_LEVEL && i_wdata[7:0] > FIFO_SIZE)
		|=> full_level == FIFO_SIZE)
		else $error("oversize level not clamped");
	level_write_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) // [R14]
		(i_wr && i_addr == `TEF_OFF_FULL_LEVEL && i_wdata[7:0] <= FIFO_SIZE)
		|=> full_level == $past(i_wdata[7:0]))
		else $error("level write mismatch");

	trace_on_c: cover property (@(posedge i_clk) o_trace_gate);
	func_and_c: cover property (@(posedge i_clk)
		gate_event[`TEF_EV_W-1:`TEF_EV_FUNC_LSB] == 3'h2 && event_ok);
	stall_c: cover property (@(posedge i_clk) o_buffer_near_full_stall);
	ss_trace_c: cover property (@(posedge i_clk) ss_en && ss_state ##1 o_trace_gate);
	excl_c: cover property (@(posedge i_clk) excl && !in_region ##1 o_trace_gate);
endmodule : tef_regs
`default_nettype wire
